// File: design/mcmi_regs.vh
`ifndef MCMI_REGS_VH
`define MCMI_REGS_VH

// Register byte offsets
`define MCMI_OFF_CTRL      6'h00
`define MCMI_OFF_STATUS    6'h04
`define MCMI_OFF_MSTEP     6'h08
`define MCMI_OFF_ENC       6'h0c
`define MCMI_OFF_DECEL     6'h10
`define MCMI_OFF_PADDR     6'h14
`define MCMI_OFF_PDATA     6'h18
`define MCMI_OFF_RUN       6'h1c
`define MCMI_OFF_CLEAR     6'h20
`define MCMI_OFF_PRINT     6'h24
`define MCMI_OFF_CMDSTAT   6'h28

// Field positions
`define MCMI_CTRL_CKSUM    0
`define MCMI_RUN_HALT      31
`define MCMI_CLEAR_ALL     31
`define MCMI_ST_RUN        0
`define MCMI_ST_CLEAR      1
`define MCMI_ST_PRINT      2

// Reset values and limits
`define MCMI_MSTEP_RST     32'h00000000
`define MCMI_ENC_RST       32'h00000000
`define MCMI_DECEL_RST     32'h000f4240
`define MCMI_DECEL_MAX     32'h5af310d5

// Program word opcodes
`define MCMI_OP_END        4'h0
`define MCMI_OP_CALL       4'h1
`define MCMI_OP_RET        4'h2
`define MCMI_OP_NEXT       4'h3

// Print selectors
`define MCMI_PR_RUN        3'h0
`define MCMI_PR_MSTEP      3'h1
`define MCMI_PR_ENC        3'h2
`define MCMI_PR_DECEL      3'h3
`define MCMI_PR_CKSUM      3'h4

// Serial characters
`define MCMI_CH_ACK        8'h06
`define MCMI_CH_NAK        8'h15
`define MCMI_CH_CR         8'h0d
`define MCMI_CK_BIT7       8'h80

// Sizes
`define MCMI_STACK_DEPTH   3'h4
`define MCMI_PRINT_BYTES   3'h4

`endif

// File: design/mcmi_cksum.v
`timescale 1ns/100ps
`include "mcmi_regs.vh"

module mcmi_cksum (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Mode
	input  wire       enable,
	// Character stream
	input  wire       char_valid,
	input  wire [7:0] char_data,
	// Result
	output reg        done,
	output reg        good
);

	reg  [6:0] sum;
	wire [6:0] expect_low;

	// Two's complement of the 7-bit running sum
	assign expect_low = (~sum) + 7'h01; // RULE_07

	always @(posedge clk) begin
		if (!rst_n) begin
			sum  <= 7'h00;
			done <= 1'b0;
			good <= 1'b0;
		end else begin
			done <= 1'b0;
			if (char_valid) begin
				// Command text is 7-bit, so bit 7 marks the checksum character
				if (char_data[7]) begin
					sum <= 7'h00;
					if (enable) begin
						done <= 1'b1; // RULE_06
						good <= (char_data == ({1'b0, expect_low} | `MCMI_CK_BIT7)); // RULE_07
					end
				end else if (char_data == `MCMI_CH_CR) begin
					// Plain mode frames on CR; no verdict is raised
					sum <= 7'h00; // RULE_18
				end else begin
					sum <= sum + char_data[6:0]; // RULE_07
				end
			end
		end
	end

endmodule // mcmi_cksum

// File: design/mcmi_top.v
// Contract
// RULE_01 - Read-only running flag, resets to zero
// RULE_02 - Signed 32-bit counter counts every step pulse; a pulse in the cycle of a preset write is lost
// RULE_03 - Host may preset step counter by writing
// RULE_04 - Signed 32-bit encoder counter, default zero
// RULE_05 - Host may preset encoder counter by writing
// RULE_06 - Enable flag demands trailing checksum per command
// RULE_07 - Checksum: 7-bit sum, negate, OR 0x80
// RULE_08 - Bad checksum replies NAK, good replies ACK
// RULE_09 - Call jumps to target when condition true
// RULE_10 - Call without condition always jumps; with 4 calls already nested the program stops instead
// RULE_11 - Return resumes at line after call
// RULE_12 - Clear erases from given line to end
// RULE_13 - Clear without parameter erases all lines
// RULE_14 - Program stored and run; clear only immediate
// RULE_15 - Deceleration 0 to max, default one million
// RULE_16 - Print sends selected value to host
// RULE_17 - Running flag set at start, cleared at end
// RULE_18 - Plain mode: no checksum, no reply
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "mcmi_regs.vh"

module mcmi_top (
	// Clock and reset
	input  wire        MCLK,
	input  wire        RST_N,
	// Wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [5:2]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// Serial receiver character stream
	input  wire        RX_VALID,
	input  wire [7:0]  RX_DATA,
	// Serial transmitter character stream
	output reg         TX_VALID,
	output reg  [7:0]  TX_DATA,
	input  wire        TX_READY,
	// Motion
	input  wire        STEP_PULSE,
	input  wire        STEP_DIR,
	input  wire        ENC_A,
	input  wire        ENC_B,
	input  wire [3:0]  COND_FLAGS,
	// Status
	output reg         PROG_RUNNING
);

	// Pin synchronisers
	reg  [5:0]  pin_meta;
	reg  [5:0]  pin_sync;
	reg  [1:0]  enc_prev;
	wire        enc_a;
	wire        enc_b;
	wire [3:0]  cond_in;

	// Registers
	reg         checksum_mode_enable;
	reg  [31:0] motor_step_counter;
	reg  [31:0] encoder_counter;
	reg  [31:0] decel;
	reg  [7:0]  prog_addr;
	reg  [15:0] prog_mem [0:255];

	// Sequencer
	reg  [7:0]  pc;
	reg  [7:0]  stack [0:3];
	reg  [2:0]  sp;
	reg         clearing;
	reg  [7:0]  clr_ptr;

	// Print and reply
	reg  [31:0] pr_val;
	reg  [2:0]  pr_cnt;
	reg         rep_pend;
	reg  [7:0]  rep_char;
	reg         last_good;
	reg         last_seen;

	// Bus decode
	wire        bus_req;
	wire        bus_wr;
	wire [5:0]  bus_off;
	reg  [31:0] rd_mux;
	reg         rd_hit;
	wire [31:0] wr_mstep;
	wire [31:0] wr_enc;
	wire [31:0] wr_decel;
	wire [31:0] wr_pdata;

	// Instruction fields
	wire [15:0] instr;
	wire [3:0]  op;
	wire [3:0]  cond_mask;
	wire [7:0]  target;
	wire        cond_ok;
	wire        run_wr;
	wire        clr_wr;
	wire        pr_wr;

	// Checksum result
	wire        ck_done;
	wire        ck_good;

	function [31:0] bmerge;
		input [31:0] old;
		input [31:0] din;
		input [3:0]  sel;
		integer i;
		begin
			bmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					bmerge[i*8 +: 8] = din[i*8 +: 8];
				end
			end
		end
	endfunction

	assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign bus_wr    = bus_req & WB_WE_I;
	assign bus_off   = {WB_ADR_I, 2'b00};
	assign wr_mstep  = bmerge(motor_step_counter, WB_DAT_I, WB_SEL_I);
	assign wr_enc    = bmerge(encoder_counter, WB_DAT_I, WB_SEL_I);
	assign wr_decel  = bmerge(decel, WB_DAT_I, WB_SEL_I);
	assign wr_pdata  = bmerge({16'h0000, prog_mem[prog_addr]}, WB_DAT_I, WB_SEL_I);
	assign run_wr    = bus_wr & (bus_off == `MCMI_OFF_RUN) & (&WB_SEL_I);
	assign clr_wr    = bus_wr & (bus_off == `MCMI_OFF_CLEAR) & (&WB_SEL_I);
	assign pr_wr     = bus_wr & (bus_off == `MCMI_OFF_PRINT) & (&WB_SEL_I);

	assign enc_a     = pin_sync[0];
	assign enc_b     = pin_sync[1];
	assign cond_in   = pin_sync[5:2];

	assign instr     = prog_mem[pc];
	assign op        = instr[15:12];
	assign cond_mask = instr[11:8];
	assign target    = instr[7:0];
	// Empty mask means unconditional
	assign cond_ok   = ((cond_in & cond_mask) == cond_mask); // RULE_09 RULE_10

	mcmi_cksum u_cksum (
		.clk        (MCLK),
		.rst_n      (RST_N),
		.enable     (checksum_mode_enable),
		.char_valid (RX_VALID),
		.char_data  (RX_DATA),
		.done       (ck_done),
		.good       (ck_good)
	);

	// Synchronise encoder and condition pins
	always @(posedge MCLK) begin
		if (!RST_N) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
			enc_prev <= 2'h0;
		end else begin
			pin_meta <= {COND_FLAGS, ENC_B, ENC_A};
			pin_sync <= pin_meta;
			enc_prev <= {enc_b, enc_a};
		end
	end

	// Bus-written settings
	always @(posedge MCLK) begin
		if (!RST_N) begin
			checksum_mode_enable <= 1'b0;
			decel                <= `MCMI_DECEL_RST; // RULE_15
			prog_addr            <= 8'h00;
		end else if (bus_wr) begin
			case (bus_off)
				`MCMI_OFF_CTRL: begin
					if (WB_SEL_I[0]) begin
						checksum_mode_enable <= WB_DAT_I[`MCMI_CTRL_CKSUM]; // RULE_06
					end
				end
				`MCMI_OFF_DECEL: begin
					// Out-of-range values are dropped, old setting kept
					if (wr_decel <= `MCMI_DECEL_MAX) begin
						decel <= wr_decel; // RULE_15
					end
				end
				`MCMI_OFF_PADDR: begin
					if (WB_SEL_I[0]) begin
						prog_addr <= WB_DAT_I[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Step counter; a preset write wins over a pulse in the same cycle
	always @(posedge MCLK) begin
		if (!RST_N) begin
			motor_step_counter <= `MCMI_MSTEP_RST; // RULE_02
		end else if (bus_wr && bus_off == `MCMI_OFF_MSTEP) begin
			motor_step_counter <= wr_mstep; // RULE_03
		end else if (STEP_PULSE) begin
			if (STEP_DIR) begin
				motor_step_counter <= motor_step_counter + 32'h00000001; // RULE_02
			end else begin
				motor_step_counter <= motor_step_counter - 32'h00000001; // RULE_02
			end
		end
	end

	// Quadrature x4 decode: count when exactly one phase moved
	always @(posedge MCLK) begin
		if (!RST_N) begin
			encoder_counter <= `MCMI_ENC_RST; // RULE_04
		end else if (bus_wr && bus_off == `MCMI_OFF_ENC) begin
			encoder_counter <= wr_enc; // RULE_05
		end else if ((enc_a ^ enc_prev[0]) ^ (enc_b ^ enc_prev[1])) begin
			if (enc_prev[0] ^ enc_b) begin
				encoder_counter <= encoder_counter + 32'h00000001; // RULE_04
			end else begin
				encoder_counter <= encoder_counter - 32'h00000001; // RULE_04
			end
		end
	end

	// Program store: bus loads words, clear engine erases one per cycle
	always @(posedge MCLK) begin
		if (!RST_N) begin
			clearing <= 1'b0;
			clr_ptr  <= 8'h00;
		end else if (clearing) begin
			prog_mem[clr_ptr] <= 16'h0000; // RULE_12 RULE_13
			clr_ptr           <= clr_ptr + 8'h01;
			if (clr_ptr == 8'hff) begin
				clearing <= 1'b0;
			end
		end else if (clr_wr && !PROG_RUNNING) begin
			// Immediate only: refused while a program runs
			clearing <= 1'b1; // RULE_14
			if (WB_DAT_I[`MCMI_CLEAR_ALL]) begin
				clr_ptr <= 8'h00; // RULE_13
			end else begin
				clr_ptr <= WB_DAT_I[7:0]; // RULE_12
			end
		end else if (bus_wr && bus_off == `MCMI_OFF_PDATA && !PROG_RUNNING) begin
			prog_mem[prog_addr] <= wr_pdata[15:0]; // RULE_14
		end
	end

	// Program sequencer, one word per cycle
	always @(posedge MCLK) begin
		if (!RST_N) begin
			PROG_RUNNING <= 1'b0; // RULE_01
			pc           <= 8'h00;
			sp           <= 3'h0;
		end else if (run_wr) begin
			if (WB_DAT_I[`MCMI_RUN_HALT]) begin
				PROG_RUNNING <= 1'b0; // RULE_17
			end else if (!PROG_RUNNING && !clearing) begin
				PROG_RUNNING <= 1'b1; // RULE_17
				pc           <= WB_DAT_I[7:0];
				sp           <= 3'h0;
			end
		end else if (PROG_RUNNING) begin
			case (op)
				`MCMI_OP_END: begin
					PROG_RUNNING <= 1'b0; // RULE_17
				end
				`MCMI_OP_CALL: begin
					if (!cond_ok) begin
						pc <= pc + 8'h01;
						if (pc == 8'hff) begin
							PROG_RUNNING <= 1'b0;
						end
					end else if (sp == `MCMI_STACK_DEPTH) begin
						// Nesting too deep: stop rather than lose a return line
						PROG_RUNNING <= 1'b0; // RULE_17
					end else begin
						stack[sp[1:0]] <= pc + 8'h01; // RULE_11
						sp             <= sp + 3'h1;
						pc             <= target; // RULE_09 RULE_10
					end
				end
				`MCMI_OP_RET: begin
					if (sp == 3'h0) begin
						PROG_RUNNING <= 1'b0; // RULE_17
					end else begin
						pc <= stack[sp[1:0] - 2'h1]; // RULE_11
						sp <= sp - 3'h1;
					end
				end
				default: begin
					pc <= pc + 8'h01;
					if (pc == 8'hff) begin
						PROG_RUNNING <= 1'b0; // RULE_17
					end
				end
			endcase
		end
	end

	// Reply engine: ACK/NAK first, then print bytes MSB first
	always @(posedge MCLK) begin
		if (!RST_N) begin
			TX_VALID  <= 1'b0;
			TX_DATA   <= 8'h00;
			rep_pend  <= 1'b0;
			rep_char  <= 8'h00;
			pr_val    <= 32'h00000000;
			pr_cnt    <= 3'h0;
			last_good <= 1'b0;
			last_seen <= 1'b0;
		end else begin
			if (ck_done) begin
				rep_pend  <= 1'b1; // RULE_08
				rep_char  <= ck_good ? `MCMI_CH_ACK : `MCMI_CH_NAK; // RULE_08
				last_good <= ck_good;
				last_seen <= 1'b1;
			end
			if (pr_wr && pr_cnt == 3'h0) begin
				pr_cnt <= `MCMI_PRINT_BYTES; // RULE_16
				case (WB_DAT_I[2:0])
					`MCMI_PR_RUN:   pr_val <= {31'h00000000, PROG_RUNNING};
					`MCMI_PR_MSTEP: pr_val <= motor_step_counter;
					`MCMI_PR_ENC:   pr_val <= encoder_counter;
					`MCMI_PR_DECEL: pr_val <= decel;
					`MCMI_PR_CKSUM: pr_val <= {31'h00000000, checksum_mode_enable};
					default:        pr_val <= 32'h00000000;
				endcase
			end
			if (TX_VALID && TX_READY) begin
				TX_VALID <= 1'b0;
			end else if (!TX_VALID) begin
				// A new verdict arriving now is kept, not dropped
				if (rep_pend && !ck_done) begin
					TX_VALID <= 1'b1;
					TX_DATA  <= rep_char; // RULE_08
					rep_pend <= 1'b0;
				end else if (pr_cnt != 3'h0 && !pr_wr) begin
					TX_VALID <= 1'b1;
					TX_DATA  <= pr_val[31:24]; // RULE_16
					pr_val   <= {pr_val[23:0], 8'h00};
					pr_cnt   <= pr_cnt - 3'h1;
				end
			end
		end
	end

	// Read mux
	always @* begin
		rd_hit = 1'b1;
		case (bus_off)
			`MCMI_OFF_CTRL:    rd_mux = {31'h00000000, checksum_mode_enable};
			`MCMI_OFF_STATUS:  rd_mux = {26'h0000000, sp, pr_cnt != 3'h0, clearing,
				PROG_RUNNING}; // RULE_01
			`MCMI_OFF_MSTEP:   rd_mux = motor_step_counter;
			`MCMI_OFF_ENC:     rd_mux = encoder_counter;
			`MCMI_OFF_DECEL:   rd_mux = decel;
			`MCMI_OFF_PADDR:   rd_mux = {24'h000000, prog_addr};
			`MCMI_OFF_PDATA:   rd_mux = {16'h0000, prog_mem[prog_addr]};
			`MCMI_OFF_RUN:     rd_mux = {24'h000000, pc};
			`MCMI_OFF_CMDSTAT: rd_mux = {30'h00000000, last_good, last_seen};
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Wishbone answer one cycle after the request is seen
	always @(posedge MCLK) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= bus_req;
			if (bus_req && !WB_WE_I) begin
				WB_DAT_O <= rd_hit ? rd_mux : 32'h00000000;
			end
		end
	end

endmodule // mcmi_top

// File: test/mcmi_top_assertions.sv
`timescale 1ns/100ps
module mcmi_chk (
	// Clock and reset
	input logic        MCLK,
	input logic        RST_N,
	// Bus
	input logic        WB_CYC_I,
	input logic        WB_STB_I,
	input logic        WB_WE_I,
	input logic [5:2]  WB_ADR_I,
	input logic [3:0]  WB_SEL_I,
	input logic [31:0] WB_DAT_I,
	input logic [31:0] WB_DAT_O,
	input logic        WB_ACK_O,
	// Serial
	input logic        RX_VALID,
	input logic [7:0]  RX_DATA,
	input logic        TX_VALID,
	input logic [7:0]  TX_DATA,
	input logic        TX_READY,
	// Motion and status
	input logic        STEP_PULSE,
	input logic        STEP_DIR,
	input logic        ENC_A,
	input logic        ENC_B,
	input logic [3:0]  COND_FLAGS,
	input logic        PROG_RUNNING
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire rdq = req && !WB_WE_I;
	a_ack_answer: assert property (req |=> WB_ACK_O)
		else $error("ack missing");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req))
		else $error("ack without request");
	a_status_run: assert property (rdq && WB_ADR_I == 4'h1 |=>
		WB_DAT_O[0] == $past(PROG_RUNNING)) else $error("status flag wrong");
	a_unmapped_zero: assert property (rdq && WB_ADR_I > 4'ha |=> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_tx_hold: assert property (TX_VALID && !TX_READY |=>
		TX_VALID && $stable(TX_DATA)) else $error("reply dropped");
	a_tx_gap: assert property (TX_VALID && TX_READY |=> !TX_VALID)
		else $error("no idle after byte");
	a_reset_quiet: assert property ($rose(RST_N) |->
		!PROG_RUNNING && !TX_VALID && !WB_ACK_O) else $error("reset state wrong");
	c_run: cover property ($rose(PROG_RUNNING));
	c_stall: cover property (TX_VALID && !TX_READY);
	c_write: cover property (req && WB_WE_I);
endmodule // mcmi_chk
bind mcmi_top mcmi_chk u_chk (.MCLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .RX_VALID, .RX_DATA,
	.TX_VALID, .TX_DATA, .TX_READY, .STEP_PULSE, .STEP_DIR, .ENC_A, .ENC_B,
	.COND_FLAGS, .PROG_RUNNING);

// File: test/mcmi_host.sv
`timescale 1ns/100ps
module mcmi_host (
	// Clock
	input  logic       MCLK,
	// Host to device
	output logic       RX_VALID,
	output logic [7:0] RX_DATA,
	// Device to host
	input  logic       TX_VALID,
	input  logic [7:0] TX_DATA,
	output logic       TX_READY
);
	logic       slow;
	logic [1:0] ph;
	logic [7:0] got[$];
	initial begin
		RX_VALID = 1'b0;
		RX_DATA  = 8'h00;
		slow     = 1'b1;
		ph       = 2'h0;
	end
	// Slow mode stalls two cycles of three
	always @(posedge MCLK) ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
	assign TX_READY = !slow || ph == 2'h0;
	always @(posedge MCLK) if (TX_VALID && TX_READY) got.push_back(TX_DATA);
	task put(input logic [7:0] c);
		@(posedge MCLK);
		RX_VALID <= 1'b1;
		RX_DATA  <= c;
		@(posedge MCLK);
		RX_VALID <= 1'b0;
		RX_DATA  <= ~c;
	endtask
	task send(input string s, input logic ck, input logic bad);
		logic [6:0] sum;
		logic [7:0] c;
		sum = 7'h00;
		for (int i = 0; i < s.len(); i++) begin
			c = s[i];
			put(c);
			sum = sum + c[6:0];
		end
		if (ck) put({1'b1, ~sum + 7'h01} ^ {7'h00, bad});
	endtask
endmodule // mcmi_host

// File: test/tb.sv
`timescale 1ns/100ps
`include "mcmi_regs.vh"
module tb;
	logic        MCLK, RST_N, cyc, stb, we, ack, step, dir, ea, eb, rv, tv, tr, run;
	logic [3:0]  sel, cf;
	logic [5:2]  adr;
	logic [7:0]  rd, td;
	logic [31:0] dat, q, dout;
	int          failures, n_compared, n;
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	mcmi_top DUT (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout),
		.WB_ACK_O(ack), .RX_VALID(rv), .RX_DATA(rd), .TX_VALID(tv), .TX_DATA(td),
		.TX_READY(tr), .STEP_PULSE(step), .STEP_DIR(dir), .ENC_A(ea), .ENC_B(eb),
		.COND_FLAGS(cf), .PROG_RUNNING(run));
	mcmi_host host (.MCLK(MCLK), .RX_VALID(rv), .RX_DATA(rd), .TX_VALID(tv),
		.TX_DATA(td), .TX_READY(tr));
	task tally_and_finish;
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h saw %h", nm, e, s);
		end
	endtask
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge MCLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a[5:2];
		dat <= d;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
		q = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task pw(input logic [7:0] l, input logic [15:0] w);
		wr(`MCMI_OFF_PADDR, {24'h0, l});
		wr(`MCMI_OFF_PDATA, {16'h0, w});
	endtask
	task pr(input logic [7:0] l, input logic [15:0] e);
		wr(`MCMI_OFF_PADDR, {24'h0, l});
		wb(1'b0, `MCMI_OFF_PDATA, 32'h0);
		chk("program word", {16'h0, q[15:0]}, {16'h0, e});
	endtask
	// Polls status because clear length depends on start line
	task clear(input logic [31:0] d);
		wr(`MCMI_OFF_CLEAR, d);
		repeat (300) begin
			wb(1'b0, `MCMI_OFF_STATUS, 32'h0);
			if (q[1] === 1'b0) return;
		end
		failures++;
		tally_and_finish();
	endtask
	task run_chk(input logic [31:0] pc);
		logic seen;
		seen = 1'b0;
		wr(`MCMI_OFF_RUN, 32'h0);
		repeat (60) begin
			@(posedge MCLK);
			if (run === 1'b1) seen = 1'b1;
			else if (seen) break;
		end
		chk("running seen", {31'h0, seen}, 32'h1);
		chk("running end", {31'h0, run}, 32'h0);
		rdc("pc", `MCMI_OFF_RUN, pc);
	endtask
	task pulse;
		@(posedge MCLK);
		step <= 1'b1;
		@(posedge MCLK);
		step <= 1'b0;
	endtask
	task wait_got(input int k);
		repeat (100) begin
			if (host.got.size() >= k) return;
			@(posedge MCLK);
		end
		failures++;
		tally_and_finish();
	endtask
	initial begin
		#3000000;
		failures++;
		tally_and_finish();
	end
	initial begin
		{RST_N, cyc, stb, we, step, dir, ea, eb} = 8'h00;
		{adr, cf, dat} = 40'h0;
		sel = 4'hf;
		failures = 0;
		n_compared = 0;
		repeat (10) @(posedge MCLK);
		RST_N <= 1'b1;
		rdc("status", `MCMI_OFF_STATUS, 32'h0);
		rdc("step", `MCMI_OFF_MSTEP, 32'h0);
		rdc("enc", `MCMI_OFF_ENC, 32'h0);
		rdc("decel", `MCMI_OFF_DECEL, 32'h000f4240);
		rdc("ctrl", `MCMI_OFF_CTRL, 32'h0);
		wr(6'h3c, 32'hffffffff);
		rdc("unmapped", 6'h3c, 32'h0);
		wr(`MCMI_OFF_DECEL, 32'h5af310d5);
		wr(`MCMI_OFF_DECEL, 32'h5af310d6);
		rdc("decel max", `MCMI_OFF_DECEL, 32'h5af310d5);
		wr(`MCMI_OFF_MSTEP, 32'h7fffffff);
		rdc("step preset", `MCMI_OFF_MSTEP, 32'h7fffffff);
		dir <= 1'b1;
		pulse();
		rdc("step up", `MCMI_OFF_MSTEP, 32'h80000000);
		dir <= 1'b0;
		pulse();
		pulse();
		rdc("step down", `MCMI_OFF_MSTEP, 32'h7ffffffe);
		wr(`MCMI_OFF_ENC, 32'h7fffffff);
		eb <= 1'b1;
		repeat (6) @(posedge MCLK);
		rdc("enc count", `MCMI_OFF_ENC, 32'h80000000);
		host.got.delete();
		wr(`MCMI_OFF_PRINT, 32'h1);
		wait_got(4);
		for (int i = 0; i < 4; i++)
			chk("print", {24'h0, host.got[i]}, (32'h7ffffffe >> (24 - 8 * i)) & 32'hff);
		host.slow <= 1'b0;
		wr(`MCMI_OFF_CTRL, 32'h1);
		rdc("ctrl on", `MCMI_OFF_CTRL, 32'h1);
		for (int b = 0; b < 2; b++) begin
			host.got.delete();
			host.send("MR 1", 1'b1, b[0]);
			wait_got(1);
			chk("verdict", {24'h0, host.got[0]}, b ? 32'h15 : 32'h06);
		end
		rdc("cmd status", `MCMI_OFF_CMDSTAT, 32'h1);
		wr(`MCMI_OFF_CTRL, 32'h0);
		host.got.delete();
		host.send("MR 1", 1'b1, 1'b0);
		repeat (20) @(posedge MCLK);
		chk("plain reply", host.got.size(), 32'h0);
		clear(32'h80000000);
		pw(8'd0, 16'h100a);
		pw(8'd1, 16'h1114);
		pw(8'd2, 16'h0000);
		pw(8'd10, 16'h2000);
		pw(8'd20, 16'h0000);
		run_chk(32'h2);
		cf <= 4'h1;
		repeat (4) @(posedge MCLK);
		run_chk(32'h14);
		wr(`MCMI_OFF_RUN, 32'h0);
		wr(`MCMI_OFF_CLEAR, 32'h80000000);
		pr(8'd1, 16'h1114);
		clear(32'ha);
		pr(8'd10, 16'h0000);
		pr(8'd1, 16'h1114);
		clear(32'h80000000);
		pr(8'd1, 16'h0000);
		tally_and_finish();
	end
endmodule // tb
